// File: hw/sps_regs.vh
// Overview of operation
// - Scheduler runs only while the port is set up as master.
// - Reply wait is timed in 1 ms units, setting 0 to 65535.
// - On reply timeout, retransmit the same command or move to next entry.
// - Retry a failing command up to 0..10 times, then count it failed.
// - Reply ends after 3.5 character times of silence plus extra ms.
// - Extra end delay of zero means only the default silence is used.
// - After a reply ends, wait the minimum gap in ms (0..32767).
// - Retries skip the minimum gap and go out at once.
// - Skip commands to a dead slave until skip count reaches setting.
// - Per-command control comes from 100 database words at base 0..3900.
// - Disabled entry with control word zero is never executed.
// - Control word one executes the command on every pass.
// - Control word two issues a write only when its data changed.
// - Control word three only for coil writes; issue on bit change.
// - In mode three, clear the database bit the cycle before the command goes out.
// - Control base of minus one turns control gating off.
`ifndef SPS_REGS_VH
`define SPS_REGS_VH
`define SPS_CTRL       12'h000
`define SPS_TIMEOUT    12'h004
`define SPS_RETRY      12'h008
`define SPS_EOM        12'h00c
`define SPS_GAP        12'h010
`define SPS_ERRSKIP    12'h014
`define SPS_CTLBASE    12'h018
`define SPS_CHARCYC    12'h01c
`define SPS_STATUS     12'h020
`define SPS_MASK       12'h024
`define SPS_STATE      12'h028
`define SPS_LIST_BASE  12'h400
`define SPS_LIST_LEN   100
`define SPS_CTL_MAX    16'h0f3c
`define SPS_RETRY_MAX  4'ha
`define SPS_CTLBASE_RST 16'hffff
`define SPS_CHARCYC_RST 16'h0a2c
`define SPS_MS_NS      1000000
`define SPS_CLK_NS     40
`define SPS_ST_ISSUE   0
`define SPS_ST_REPLY   1
`define SPS_ST_TMO     2
`define SPS_ST_FAIL    3
`define SPS_ST_WRAP    4
`define SPS_ST_W       5
// Entry field positions
`define SPS_E_EN       0
`define SPS_E_WR       1
`define SPS_E_BIT      2
`define SPS_E_SLV_LO   8
`define SPS_E_BIX_LO   16
`define SPS_E_ADR_LO   20
`endif

// File: hw/sps_sched.v
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_sched #(
  parameter MS_CYCLES = `SPS_MS_NS / `SPS_CLK_NS
) (
  // Clock, reset, enable
  input  wire        i_core_clk,
  input  wire        i_reset,
  input  wire        i_ce,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  // Link side
  input  wire        i_rx_char,
  output reg         o_tx_start,
  output reg  [7:0]  o_tx_slave,
  output reg  [6:0]  o_tx_index,
  output reg         o_tx_retry,
  // Internal database port
  output reg         o_db_rd,
  output reg         o_db_we,
  output reg  [11:0] o_db_addr,
  output reg  [15:0] o_db_wdata,
  input  wire [15:0] i_db_rdata,
  // Interrupt
  output reg         o_irq
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_PICK = 4'h1;
  localparam S_CTLW = 4'h2;
  localparam S_CTL  = 4'h3;
  localparam S_DATW = 4'h4;
  localparam S_DAT  = 4'h5;
  localparam S_ISSU = 4'h6;
  localparam S_WAIT = 4'h7;
  localparam S_GAP  = 4'h8;
  localparam S_NEXT = 4'h9;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        master_en;
  reg [15:0] timeout;
  reg [3:0]  retry_max;
  reg [15:0] eom_ms;
  reg [14:0] gap_ms;
  reg [15:0] err_skip;
  reg [15:0] ctl_base;
  reg [15:0] char_cyc;
  reg [`SPS_ST_W-1:0] status;
  reg [`SPS_ST_W-1:0] mask;
  reg [31:0] list [0:`SPS_LIST_LEN-1];
  reg [15:0] last [0:`SPS_LIST_LEN-1];
  reg        dead [0:255];
  reg [15:0] skipn [0:255];

  reg [3:0]  state;
  reg [6:0]  idx;
  reg [3:0]  tries;
  reg [1:0]  ctl_word;
  reg [15:0] ms_div;
  reg        ms_tick;
  reg [15:0] t_ms;
  reg [17:0] sil;
  reg        got;
  reg [`SPS_ST_W-1:0] ev;

  wire        acc    = i_psel & i_penable & o_pready;
  wire        wr     = acc & i_pwrite;
  wire        in_lst = (i_paddr >= `SPS_LIST_BASE) &&
                       (i_paddr < `SPS_LIST_BASE + 12'd400);
  wire [11:0] loff   = i_paddr - `SPS_LIST_BASE;
  wire [6:0]  lidx   = loff[8:2];
  wire [31:0] ent    = list[idx];
  wire [7:0]  slv    = ent[`SPS_E_SLV_LO +: 8];
  wire [11:0] dadr   = ent[`SPS_E_ADR_LO +: 12];
  wire [3:0]  bix    = ent[`SPS_E_BIX_LO +: 4];
  wire        gating = ~ctl_base[15] && (ctl_base <= `SPS_CTL_MAX);
  // 3.5 characters as seven half characters
  wire [19:0] sil_x7  = {4'h0, char_cyc} * 20'd7;
  wire [17:0] sil_thr = sil_x7[18:1];
  wire [15:0] dbit    = 16'h0001 << bix;
  // Slow poll of a failed slave
  wire        skip_slv = dead[slv] && (skipn[slv] != err_skip);

  // ----------------------------------------
  // Millisecond prescaler
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      ms_div  <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (i_ce) begin
      ms_tick <= (ms_div == MS_CYCLES[15:0] - 16'h0001);
      if (ms_div == MS_CYCLES[15:0] - 16'h0001)
        ms_div <= 16'h0000;
      else
        ms_div <= ms_div + 16'h0001;
    end
  end

  // ----------------------------------------
  // APB slave, one wait state per access
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
      master_en <= 1'b0;
      timeout   <= 16'h0000;
      retry_max <= 4'h0;
      eom_ms    <= 16'h0000;
      gap_ms    <= 15'h0000;
      err_skip  <= 16'h0000;
      ctl_base  <= `SPS_CTLBASE_RST;
      char_cyc  <= `SPS_CHARCYC_RST;
      mask      <= {`SPS_ST_W{1'b0}};
    end else if (i_ce) begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel & i_penable & ~o_pready) begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h00000000;
        case (i_paddr)
          `SPS_CTRL:    o_prdata <= {31'h0, master_en};
          `SPS_TIMEOUT: o_prdata <= {16'h0, timeout};
          `SPS_RETRY:   o_prdata <= {28'h0, retry_max};
          `SPS_EOM:     o_prdata <= {16'h0, eom_ms};
          `SPS_GAP:     o_prdata <= {17'h0, gap_ms};
          `SPS_ERRSKIP: o_prdata <= {16'h0, err_skip};
          `SPS_CTLBASE: o_prdata <= {16'h0, ctl_base};
          `SPS_CHARCYC: o_prdata <= {16'h0, char_cyc};
          `SPS_STATUS:  o_prdata <= {27'h0, status};
          `SPS_MASK:    o_prdata <= {27'h0, mask};
          `SPS_STATE:   o_prdata <= {17'h0, tries, idx, state};
          default: begin
            if (in_lst && i_paddr[1:0] == 2'b00)
              o_prdata <= list[lidx];
            else
              o_pslverr <= 1'b1;
          end
        endcase
      end
      if (wr) begin
        case (i_paddr)
          `SPS_CTRL:    master_en <= i_pwdata[0];
          `SPS_TIMEOUT: timeout   <= i_pwdata[15:0];
          `SPS_RETRY: begin
            // Settings above ten are held at ten
            if (i_pwdata[3:0] > `SPS_RETRY_MAX || |i_pwdata[31:4])
              retry_max <= `SPS_RETRY_MAX;
            else
              retry_max <= i_pwdata[3:0];
          end
          `SPS_EOM:     eom_ms    <= i_pwdata[15:0];
          `SPS_GAP:     gap_ms    <= i_pwdata[14:0];
          `SPS_ERRSKIP: err_skip  <= i_pwdata[15:0];
          `SPS_CTLBASE: ctl_base  <= i_pwdata[15:0];
          `SPS_CHARCYC: char_cyc  <= i_pwdata[15:0];
          `SPS_MASK:    mask      <= i_pwdata[`SPS_ST_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Entry table, written by software only
  always @(posedge i_core_clk) begin
    if (i_ce && wr && in_lst && i_paddr[1:0] == 2'b00)
      list[lidx] <= i_pwdata;
  end

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      status <= {`SPS_ST_W{1'b0}};
      o_irq  <= 1'b0;
    end else if (i_ce) begin
      // A new event wins over a clearing write
      if (wr && i_paddr == `SPS_STATUS)
        status <= (status & ~i_pwdata[`SPS_ST_W-1:0]) | ev;
      else
        status <= status | ev;
      o_irq <= |(status & mask);
    end
  end

  // ----------------------------------------
  // Scheduler
  // ----------------------------------------
  integer k;
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      state      <= S_IDLE;
      idx        <= 7'h00;
      tries      <= 4'h0;
      ctl_word   <= 2'b00;
      t_ms       <= 16'h0000;
      sil        <= 18'h00000;
      got        <= 1'b0;
      ev         <= {`SPS_ST_W{1'b0}};
      o_tx_start <= 1'b0;
      o_tx_slave <= 8'h00;
      o_tx_index <= 7'h00;
      o_tx_retry <= 1'b0;
      o_db_rd    <= 1'b0;
      o_db_we    <= 1'b0;
      o_db_addr  <= 12'h000;
      o_db_wdata <= 16'h0000;
      for (k = 0; k < 256; k = k + 1) begin
        dead[k]  <= 1'b0;
        skipn[k] <= 16'h0000;
      end
      for (k = 0; k < `SPS_LIST_LEN; k = k + 1)
        last[k] <= 16'h0000;
    end else if (i_ce) begin
      ev         <= {`SPS_ST_W{1'b0}};
      o_tx_start <= 1'b0;
      o_db_rd    <= 1'b0;
      o_db_we    <= 1'b0;
      case (state)
        S_IDLE: begin
          if (master_en)
            state <= S_PICK;
        end
        S_PICK: begin
          tries <= 4'h0;
          if (!master_en) begin
            state <= S_IDLE;
          end else if (!ent[`SPS_E_EN] && gating) begin
            o_db_rd   <= 1'b1;
            o_db_addr <= ctl_base[11:0] + {5'h00, idx};
            state     <= S_CTLW;
          end else if (!ent[`SPS_E_EN]) begin
            state <= S_NEXT;
          end else begin
            state <= S_ISSU;
          end
        end
        S_CTLW: state <= S_CTL;
        S_CTL: begin
          ctl_word <= i_db_rdata[1:0];
          if (i_db_rdata == 16'h0001) begin
            state <= S_ISSU;
          end else if ((i_db_rdata == 16'h0002 && ent[`SPS_E_WR]) ||
                       (i_db_rdata == 16'h0003 && ent[`SPS_E_BIT])) begin
            o_db_rd   <= 1'b1;
            o_db_addr <= dadr;
            state     <= S_DATW;
          end else begin
            state <= S_NEXT;
          end
        end
        S_DATW: state <= S_DAT;
        S_DAT: begin
          if (ctl_word == 2'b10) begin
            // Skipped send keeps the old copy, so the change is not lost
            if (!skip_slv)
              last[idx] <= i_db_rdata;
            if (i_db_rdata != last[idx])
              state <= S_ISSU;
            else
              state <= S_NEXT;
          end else begin
            // Bit is cleared the cycle before the send, so the stored copy goes to zero
            last[idx] <= 16'h0000;
            if ((i_db_rdata & dbit) != (last[idx] & dbit)) begin
              // No clear for a skipped slave, the bit waits for its send
              if (!skip_slv) begin
                o_db_we    <= 1'b1;
                o_db_addr  <= dadr;
                o_db_wdata <= i_db_rdata & ~dbit;
              end
              state      <= S_ISSU;
            end else begin
              state <= S_NEXT;
            end
          end
        end
        S_ISSU: begin
          if (skip_slv) begin
            skipn[slv] <= skipn[slv] + 16'h0001;
            state      <= S_NEXT;
          end else begin
            dead[slv]  <= 1'b0;
            skipn[slv] <= 16'h0000;
            o_tx_start <= 1'b1;
            o_tx_slave <= slv;
            o_tx_index <= idx;
            o_tx_retry <= (tries != 4'h0);
            ev[`SPS_ST_ISSUE] <= 1'b1;
            t_ms  <= 16'h0000;
            sil   <= 18'h00000;
            got   <= 1'b0;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (i_rx_char) begin
            got  <= 1'b1;
            sil  <= 18'h00000;
            t_ms <= 16'h0000;
          end else if (got) begin
            if (sil < sil_thr)
              sil <= sil + 18'h00001;
            else if (t_ms < eom_ms) begin
              if (ms_tick)
                t_ms <= t_ms + 16'h0001;
            end else begin
              // Zero extra delay ends on silence alone
              ev[`SPS_ST_REPLY] <= 1'b1;
              t_ms  <= 16'h0000;
              state <= S_GAP;
            end
          end else if (t_ms >= timeout) begin
            ev[`SPS_ST_TMO] <= 1'b1;
            if (tries < retry_max) begin
              tries <= tries + 4'h1;
              state <= S_ISSU;
            end else begin
              dead[slv]  <= 1'b1;
              skipn[slv] <= 16'h0000;
              ev[`SPS_ST_FAIL] <= 1'b1;
              state <= S_NEXT;
            end
          end else if (ms_tick) begin
            t_ms <= t_ms + 16'h0001;
          end
        end
        S_GAP: begin
          if (t_ms >= {1'b0, gap_ms})
            state <= S_NEXT;
          else if (ms_tick)
            t_ms <= t_ms + 16'h0001;
        end
        S_NEXT: begin
          if (idx == `SPS_LIST_LEN - 1) begin
            idx <= 7'h00;
            ev[`SPS_ST_WRAP] <= 1'b1;
          end else begin
            idx <= idx + 7'h01;
          end
          state <= S_PICK;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// File: sim/sps_sched_asserts.sv
`timescale 1ns/1ps
module sps_sched_asserts #(
  parameter MS_CYCLES = 25000
) (
  input wire        i_core_clk,
  input wire        i_reset,
  input wire        i_ce,
  input wire        i_psel,
  input wire        i_penable,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        i_rx_char,
  input wire        o_tx_start,
  input wire [7:0]  o_tx_slave,
  input wire [6:0]  o_tx_index,
  input wire        o_tx_retry,
  input wire        o_db_we,
  input wire [15:0] o_db_wdata,
  input wire [15:0] i_db_rdata,
  input wire        o_irq
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_clear_send;
    o_db_we ##1 o_tx_start;
  endsequence
  a_apb_one_wait: assert property (i_ce && i_psel && i_penable && !o_pready
    |=> o_pready) else $error("pready late");
  a_pready_pulse: assert property (o_pready && i_ce |=> !o_pready)
    else $error("pready held");
  a_err_with_ready: assert property (!$stable(o_pslverr) |-> o_pready)
    else $error("pslverr moved alone");
  a_start_pulse: assert property (o_tx_start && i_ce |=> !o_tx_start)
    else $error("start held");
  a_slave_held: assert property (!$stable(o_tx_slave) |-> o_tx_start)
    else $error("slave id moved");
  a_retry_same: assert property (o_tx_start && o_tx_retry |->
    $stable(o_tx_index) && $stable(o_tx_slave)) else $error("retry moved");
  a_rx_silence: assert property (i_rx_char |=> !o_tx_start [*3])
    else $error("start during reply");
  a_clear_send: assert property (o_db_we |-> s_clear_send)
    else $error("no send after clear");
  a_clear_bits: assert property (o_db_we |->
    (o_db_wdata | $past(i_db_rdata)) == $past(i_db_rdata)
    && o_db_wdata != $past(i_db_rdata)) else $error("bit not cleared");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_reset && i_ce |=> !o_tx_start && !o_irq && !o_pready)
    else $error("output during reset");
endmodule

bind sps_sched sps_sched_asserts #(.MS_CYCLES(MS_CYCLES)) sps_sched_asserts_inst (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_rx_char(i_rx_char), .o_tx_start(o_tx_start),
  .o_tx_slave(o_tx_slave), .o_tx_index(o_tx_index),
  .o_tx_retry(o_tx_retry), .o_db_we(o_db_we), .o_db_wdata(o_db_wdata),
  .i_db_rdata(i_db_rdata), .o_irq(o_irq)
);

// File: sim/sps_sched_tb_top.sv
`timescale 1ns/1ps
module sps_sched_tb_top;
  typedef struct {
    logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;
  } sps_row_t;
  logic        i_core_clk = 1'b0;
  logic        i_reset    = 1'b1;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [11:0] i_paddr    = 12'h000;
  logic [31:0] i_pwdata   = 32'h0;
  logic [15:0] i_db_rdata = 16'h0;
  logic        i_ce       = 1'b1;
  logic [7:0]  dead       = 8'h06;
  logic [15:0] mem [0:4095];
  logic [31:0] rdat;
  logic        rerr;
  logic [7:0]  q [$];
  logic [7:0]  sl [$];
  int          t [$];
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  int          k2;
  wire  [31:0] o_prdata;
  wire  [11:0] o_db_addr;
  wire  [15:0] o_db_wdata;
  wire  [7:0]  o_tx_slave;
  wire  [6:0]  o_tx_index;
  wire         o_pready, o_pslverr, i_rx_char, o_tx_start, o_tx_retry;
  wire         o_db_rd, o_db_we, o_irq;
  logic [7:0]  exp1 [6] = '{8'h00, 8'h01, 8'h81, 8'h00, 8'h00, 8'h01};
  sps_row_t    rows [13] = '{
    '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h018, 32'h0, 32'hffff, 1'b0}, '{1'b0, 12'h01c, 32'h0, 32'ha2c, 1'b0},
    '{1'b0, 12'h020, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h024, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h008, 32'hf, 32'ha, 1'b0}, '{1'b1, 12'h030, 32'h1, 32'h0, 1'b1},
    '{1'b0, 12'h028, 32'h0, 32'h0, 1'b0}};

  sps_sched #(.MS_CYCLES(10)) sps_sched_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_rx_char(i_rx_char),
    .o_tx_start(o_tx_start), .o_tx_slave(o_tx_slave),
    .o_tx_index(o_tx_index), .o_tx_retry(o_tx_retry), .o_db_rd(o_db_rd),
    .o_db_we(o_db_we), .o_db_addr(o_db_addr), .o_db_wdata(o_db_wdata),
    .i_db_rdata(i_db_rdata), .o_irq(o_irq));
  sps_slave_model sps_slave_model_inst (
    .i_core_clk(i_core_clk), .i_tx_start(o_tx_start),
    .i_tx_slave(o_tx_slave), .i_dead(dead), .o_rx_char(i_rx_char));

  // ----------------------------
  // Clock, database, monitor
  // ----------------------------
  always #20 i_core_clk = ~i_core_clk;
  initial foreach (mem[i]) mem[i] = 16'h0;
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_db_rd) i_db_rdata <= mem[o_db_addr];
    if (o_db_we) mem[o_db_addr] <= o_db_wdata;
    if (o_tx_start) begin
      q.push_back({o_tx_retry, o_tx_index});
      sl.push_back(o_tx_slave);
      t.push_back(cyc);
    end
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  // -----
  // Tasks
  // -----
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    @(posedge i_core_clk);
    while (o_pready !== 1'b1) @(posedge i_core_clk);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // Entries are not reset, so every slot is written
  task list(input logic [31:0] e0, input logic [31:0] e1,
            input logic [31:0] e2);
    for (int i = 0; i < 100; i++)
      apb(1'b1, 12'(12'h400 + 4 * i),
          i == 0 ? e0 : (i == 1 ? e1 : (i == 2 ? e2 : 32'h0)));
  endtask
  task wait_q(input int k);
    while (q.size() < k) @(posedge i_core_clk);
  endtask

  // ---------
  // Sequence
  // ---------
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rdat, rows[i].x);
      chk(32'(rerr), 32'(rows[i].e));
    end
    list(32'h0000_0501, 32'h0000_0601, 32'h0);
    apb(1'b1, 12'h01c, 32'h4);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b1, 12'h010, 32'h5);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h024, 32'h10);
    apb(1'b1, 12'h000, 32'h1);
    wait_q(6);
    foreach (exp1[i])
      chk(32'(q[i]), 32'(exp1[i]));
    chk(32'(sl[2]), 32'h6);
    // Silence, extra end delay and gap all lie between the two sends
    chk(32'(t[1] - t[0] inside {[95:130]}), 32'h1);
    chk(32'(t[2] - t[1] inside {[10:25]}), 32'h1);
    chk(32'(o_irq), 32'h1);
    apb(1'b1, 12'h024, 32'h0);
    repeat (2) @(posedge i_core_clk);
    chk(32'(o_irq), 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    repeat (100) @(posedge i_core_clk);
    apb(1'b1, 12'h020, 32'h1f);
    n = q.size();
    apb(1'b1, 12'h024, 32'h10);
    repeat (200) @(posedge i_core_clk);
    chk(32'(q.size()), 32'(n));
    chk(32'(o_irq), 32'h0);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    dead <= 8'hff;
    q.delete();
    sl.delete();
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat, 32'h0);
    mem[201] = 16'h3;
    mem[202] = 16'h2;
    mem[32] = 16'h0009;
    list(32'h0000_0500, 32'h0203_0904, 32'h0300_0702);
    apb(1'b1, 12'h01c, 32'h4);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h018, 32'd200);
    apb(1'b1, 12'h000, 32'h1);
    repeat (400) @(posedge i_core_clk);
    chk(32'(q.size()), 32'h1);
    chk(32'(q[0]), 32'h1);
    chk(32'(sl[0]), 32'h9);
    chk(32'(mem[32]), 32'h1);
    mem[200] = 16'h1;
    wait_q(3);
    chk(32'(q[1]), 32'h0);
    chk(32'(q[2]), 32'h0);
    // Mode two sends once per change of its data word
    n = q.size();
    mem[48] = 16'h5;
    repeat (1200) @(posedge i_core_clk);
    k2 = 0;
    for (int i = n; i < q.size(); i++)
      if (q[i] == 8'h02) begin
        k2++;
        chk(32'(sl[i]), 32'h7);
      end
    chk(32'(k2), 32'h1);
    // Enable low right after a send freezes the wait
    wait_q(q.size() + 1);
    i_ce <= 1'b0;
    n = q.size();
    repeat (100) @(posedge i_core_clk);
    chk(32'(q.size()), 32'(n));
    i_ce <= 1'b1;
    wait_q(n + 1);
    end_sim();
  end
endmodule

// File: sim/sps_slave_model.sv
`timescale 1ns/1ps
module sps_slave_model (
  input  wire       i_core_clk,
  input  wire       i_tx_start,
  input  wire [7:0] i_tx_slave,
  input  wire [7:0] i_dead,
  output logic      o_rx_char
);
  // -----
  // Reply
  // -----
  // Dead id stays silent so the timeout path runs
  initial o_rx_char = 1'b0;
  always @(posedge i_core_clk) begin
    if (i_tx_start && i_tx_slave != i_dead) begin
      repeat (4) begin
        repeat (3) @(posedge i_core_clk);
        o_rx_char <= 1'b1;
        @(posedge i_core_clk);
        o_rx_char <= 1'b0;
      end
    end
  end
endmodule
